// *** core/ccdt_phase_pair.sv ***
`timescale 1ns/10ps
`default_nettype none

module ccdt_phase_pair (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Control
  input wire logic set_in,
  input wire logic phase1_in,
  // Complementary outputs once set, both low from reset until the first set
  output logic phase1_out,
  output logic phase2_out
);

  typedef struct packed {
    logic phase1;
    logic phase2;
  } ccdt_pair_state_t;

  ccdt_pair_state_t state_reg;
  ccdt_pair_state_t state_next;

  // Both edges in one cycle, crossing at mid swing
  always_comb begin
    state_next = state_reg;
    if (set_in) begin
      state_next.phase1 = phase1_in;
      state_next.phase2 = ~phase1_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= '{phase1: 1'b0, phase2: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign phase1_out = state_reg.phase1;
  assign phase2_out = state_reg.phase2;

endmodule // ccdt_phase_pair

`default_nettype wire

// *** core/ccdt_pkg.sv ***
package ccdt_pkg;

  // System clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Vertical and transfer gate timing
  localparam int unsigned VERT_PULSE_MIN_US = 6;
  localparam int unsigned VERT_PULSE_TYP_US = 8;
  localparam int unsigned VERT_PULSE_CYC = (VERT_PULSE_TYP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Horizontal and summing gate timing
  localparam int unsigned HORZ_PULSE_MIN_NS = 500;
  localparam int unsigned HORZ_PULSE_TYP_NS = 2000;
  localparam int unsigned HORZ_PULSE_CYC = (HORZ_PULSE_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset gate high time
  localparam int unsigned RESET_PULSE_MIN_NS = 100;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Transfer gate to first horizontal phase-1 overlap
  localparam int unsigned OVERLAP_MIN_US = 3;
  localparam int unsigned OVERLAP_CYC = (OVERLAP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pixel rate ceiling, in kHz
  localparam int unsigned PIXEL_RATE_MAX_KHZ = 1000;
  localparam int unsigned PIXEL_RATE_TYP_KHZ = 250;

  // Frame geometry
  localparam int unsigned ACTIVE_LINES = 122;
  localparam int unsigned BEVEL_LINES = 6;
  localparam int unsigned FRAME_LINES = ACTIVE_LINES + BEVEL_LINES;

  // Counter widths
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned LINE_W = 8;
  localparam int unsigned PIXEL_W = 11;

  // Horizontal pixels per line, default for the wider variant
  localparam logic [PIXEL_W-1:0] PIXELS_PER_LINE_DEF = 11'h414;

  // Counter reset values
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
  localparam logic [LINE_W-1:0] LINE_RESET = 8'h00;
  localparam logic [PIXEL_W-1:0] PIXEL_RESET = 11'h000;

endpackage : ccdt_pkg

// *** core/ccdt_readout.sv ***
`timescale 1ns/10ps
`default_nettype none

module ccdt_readout
  import ccdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Frame control
  input wire logic start_in,
  input wire logic [TIMER_W-1:0] integration_cycles_in,
  input wire logic [PIXEL_W-1:0] pixels_per_line_in,
  // Sensor clocks
  output logic vertical_clock_phase1_out,
  output logic vertical_clock_phase2_out,
  output logic transfer_gate_out,
  output logic horizontal_clock_phase1_out,
  output logic horizontal_clock_phase2_out,
  output logic summing_gate_out,
  output logic reset_gate_out,
  // Shutter and status
  output logic shutter_open_out,
  output logic busy_out,
  output logic line_valid_out,
  output logic pixel_sample_out,
  output logic frame_done_out
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_INTEGRATE = 4'h1,
    ST_VERT_A = 4'h2,
    ST_VERT_B = 4'h3,
    ST_OVERLAP = 4'h4,
    ST_RESET_PULSE = 4'h5,
    ST_HORZ_HIGH = 4'h6,
    ST_HORZ_LOW = 4'h7,
    ST_LINE_END = 4'h8
  } ccdt_state_t;

  typedef struct packed {
    ccdt_state_t fsm;
    logic [LINE_W-1:0] line;
    logic [PIXEL_W-1:0] pixel;
    logic [PIXEL_W-1:0] pixels_per_line;
    logic shutter_open;
    logic reset_gate;
    logic busy;
    logic line_valid;
    logic pixel_sample;
    logic frame_done;
    logic timer_busy;
  } ccdt_main_state_t;

  ccdt_main_state_t state_reg;
  ccdt_main_state_t state_next;

  logic timer_load;
  logic [TIMER_W-1:0] timer_count;
  logic timer_done;
  logic vert_set;
  logic vert_phase1;
  logic horz_set;
  logic horz_phase1;
  logic vert_p1;
  logic vert_p2;
  logic horz_p1;
  logic horz_p2;

  ccdt_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .done_out(timer_done)
  );

  ccdt_phase_pair u_vert_pair (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .set_in(vert_set),
    .phase1_in(vert_phase1),
    .phase1_out(vert_p1),
    .phase2_out(vert_p2)
  );

  ccdt_phase_pair u_horz_pair (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .set_in(horz_set),
    .phase1_in(horz_phase1),
    .phase1_out(horz_p1),
    .phase2_out(horz_p2)
  );

  always_comb begin
    state_next = state_reg;
    state_next.pixel_sample = 1'b0;
    state_next.frame_done = 1'b0;
    timer_load = 1'b0;
    timer_count = TIMER_RESET;
    vert_set = 1'b0;
    vert_phase1 = 1'b0;
    horz_set = 1'b0;
    horz_phase1 = 1'b0;
    if (timer_done) begin
      state_next.timer_busy = 1'b0;
    end
    case (state_reg.fsm)
      ST_IDLE: begin
        state_next.busy = 1'b0;
        if (start_in) begin
          state_next.shutter_open = 1'b1;
          state_next.busy = 1'b1;
          state_next.line = LINE_RESET;
          state_next.pixels_per_line = (pixels_per_line_in == PIXEL_RESET) ?
            PIXELS_PER_LINE_DEF : pixels_per_line_in;
          timer_load = 1'b1;
          timer_count = (integration_cycles_in == TIMER_RESET) ? 16'h0001 : integration_cycles_in;
          state_next.timer_busy = 1'b1;
          // Vertical rests with phase 1 low and phase 2 high
          vert_set = 1'b1;
          vert_phase1 = 1'b0;
          horz_set = 1'b1;
          horz_phase1 = 1'b0;
          state_next.fsm = ST_INTEGRATE;
        end
      end
      ST_INTEGRATE: begin
        if (timer_done) begin
          state_next.shutter_open = 1'b0;
          vert_set = 1'b1;
          vert_phase1 = 1'b1;
          timer_load = 1'b1;
          timer_count = TIMER_W'(VERT_PULSE_CYC);
          state_next.fsm = ST_VERT_A;
        end
      end
      ST_VERT_A: begin
        if (timer_done) begin
          vert_set = 1'b1;
          vert_phase1 = 1'b0;
          timer_load = 1'b1;
          // phase 2 and transfer gate high time before the overlap wait
          timer_count = TIMER_W'(VERT_PULSE_CYC);
          state_next.fsm = ST_VERT_B;
        end
      end
      ST_VERT_B: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_count = TIMER_W'(OVERLAP_CYC);
          state_next.fsm = ST_OVERLAP;
        end
      end
      ST_OVERLAP: begin
        if (timer_done) begin
          state_next.pixel = PIXEL_RESET;
          state_next.line_valid = 1'b1;
          state_next.reset_gate = 1'b1;
          timer_load = 1'b1;
          timer_count = TIMER_W'(RESET_PULSE_CYC);
          state_next.fsm = ST_RESET_PULSE;
        end
      end
      ST_RESET_PULSE: begin
        if (timer_done) begin
          state_next.reset_gate = 1'b0;
          horz_set = 1'b1;
          horz_phase1 = 1'b1;
          timer_load = 1'b1;
          timer_count = TIMER_W'(HORZ_PULSE_CYC);
          state_next.fsm = ST_HORZ_HIGH;
        end
      end
      ST_HORZ_HIGH: begin
        if (timer_done) begin
          horz_set = 1'b1;
          horz_phase1 = 1'b0;
          timer_load = 1'b1;
          timer_count = TIMER_W'(HORZ_PULSE_CYC - RESET_PULSE_CYC);
          state_next.pixel_sample = 1'b1;
          state_next.fsm = ST_HORZ_LOW;
        end
      end
      ST_HORZ_LOW: begin
        if (timer_done) begin
          // one pixel per 4 us period
          if (state_reg.pixel == state_reg.pixels_per_line - 11'h001) begin
            state_next.line_valid = 1'b0;
            state_next.fsm = ST_LINE_END;
          end else begin
            state_next.pixel = state_reg.pixel + 11'h001;
            state_next.reset_gate = 1'b1;
            timer_load = 1'b1;
            timer_count = TIMER_W'(RESET_PULSE_CYC);
            state_next.fsm = ST_RESET_PULSE;
          end
        end
      end
      ST_LINE_END: begin
        if (state_reg.line == LINE_W'(FRAME_LINES - 1)) begin
          state_next.busy = 1'b0;
          state_next.frame_done = 1'b1;
          state_next.fsm = ST_IDLE;
        end else begin
          state_next.line = state_reg.line + 8'h01;
          vert_set = 1'b1;
          vert_phase1 = 1'b1;
          timer_load = 1'b1;
          timer_count = TIMER_W'(VERT_PULSE_CYC);
          state_next.fsm = ST_VERT_A;
        end
      end
      default: begin
        state_next.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= '{fsm: ST_IDLE, line: LINE_RESET, pixel: PIXEL_RESET,
                     pixels_per_line: PIXELS_PER_LINE_DEF, shutter_open: 1'b0,
                     reset_gate: 1'b0, busy: 1'b0, line_valid: 1'b0,
                     pixel_sample: 1'b0, frame_done: 1'b0, timer_busy: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign vertical_clock_phase1_out = vert_p1;
  assign vertical_clock_phase2_out = vert_p2;
  // transfer gate copies vertical phase 2
  assign transfer_gate_out = vert_p2;
  assign horizontal_clock_phase1_out = horz_p1;
  assign horizontal_clock_phase2_out = horz_p2;
  // summing gate copies horizontal phase 2
  assign summing_gate_out = horz_p2;
  assign reset_gate_out = state_reg.reset_gate;
  assign shutter_open_out = state_reg.shutter_open;
  assign busy_out = state_reg.busy;
  assign line_valid_out = state_reg.line_valid;
  assign pixel_sample_out = state_reg.pixel_sample;
  assign frame_done_out = state_reg.frame_done;

endmodule // ccdt_readout

`default_nettype wire

// *** core/ccdt_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module ccdt_timer
  import ccdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Control
  input wire logic load_in,
  input wire logic [TIMER_W-1:0] count_in,
  // Status
  output logic done_out
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic done;
  } ccdt_timer_state_t;

  ccdt_timer_state_t state_reg;
  ccdt_timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    // Done leads zero by one cycle, so a reload on done spans exactly count_in cycles
    if (load_in) begin
      state_next.count = count_in;
      state_next.done = (count_in == 16'h0001);
    end else if (state_reg.count != TIMER_RESET) begin
      state_next.count = state_reg.count - 16'h0001;
      state_next.done = (state_reg.count == 16'h0002);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= '{count: TIMER_RESET, done: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign done_out = state_reg.done;

endmodule // ccdt_timer

`default_nettype wire

// *** verif/ccdt_readout_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccdt_readout_props (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Sensor clocks
  input wire logic vertical_clock_phase1_out,
  input wire logic vertical_clock_phase2_out,
  input wire logic transfer_gate_out,
  input wire logic horizontal_clock_phase1_out,
  input wire logic horizontal_clock_phase2_out,
  input wire logic summing_gate_out,
  input wire logic reset_gate_out,
  // Status
  input wire logic shutter_open_out,
  input wire logic busy_out,
  input wire logic line_valid_out,
  input wire logic pixel_sample_out,
  input wire logic frame_done_out
);
  logic [4:0] sig;
  logic [15:0] hi_reg [5];
  logic [15:0] gap_reg;
  logic [7:0] line_reg;
  logic v1_d_reg;
  assign sig = {reset_gate_out, summing_gate_out, horizontal_clock_phase1_out, vertical_clock_phase2_out,
    vertical_clock_phase1_out};
  // High-time counters, saturating
  always_ff @(posedge clk_sys_in) begin
    for (int i = 0; i < 5; i++) begin
      hi_reg[i] <= (reset_in || !sig[i]) ? 16'h0000 : hi_reg[i] + {15'h0000, hi_reg[i] != 16'hFFFF};
    end
    if (reset_in) begin
      gap_reg <= 16'hFFFF;
    end else begin
      gap_reg <= pixel_sample_out ? 16'h0001 : gap_reg + {15'h0000, gap_reg != 16'hFFFF};
    end
    v1_d_reg <= vertical_clock_phase1_out;
    line_reg <= shutter_open_out ? 8'h00 : line_reg + {7'h00, vertical_clock_phase1_out && !v1_d_reg};
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  v1_width_a: assert property ($fell(vertical_clock_phase1_out) |-> hi_reg[0] >= 16'h0258)
    else $error("vertical pulse too short");
  h_duty_a: assert property ($fell(horizontal_clock_phase1_out) |-> hi_reg[2] == 16'h00C8)
    else $error("horizontal high time wrong");
  sg_width_a: assert property ($fell(summing_gate_out) |-> hi_reg[3] >= 16'h0032)
    else $error("summing gate pulse too short");
  rg_width_a: assert property ($fell(reset_gate_out) |-> hi_reg[4] >= 16'h000A)
    else $error("reset gate pulse too short");
  overlap_a: assert property ($rose(horizontal_clock_phase1_out) |-> hi_reg[1] >= 16'h0384)
    else $error("transfer to horizontal overlap too short");
  pair_cross_a: assert property (busy_out |-> vertical_clock_phase1_out != vertical_clock_phase2_out
    && horizontal_clock_phase1_out != horizontal_clock_phase2_out) else $error("phase pair not complementary");
  tg_copy_a: assert property (transfer_gate_out == vertical_clock_phase2_out)
    else $error("transfer gate differs from vertical phase 2");
  sg_copy_a: assert property (summing_gate_out == horizontal_clock_phase2_out)
    else $error("summing gate differs from horizontal phase 2");
  frame_lines_a: assert property (frame_done_out |-> line_reg == 8'h80)
    else $error("frame line count wrong");
  shutter_shut_a: assert property (shutter_open_out |-> busy_out && !vertical_clock_phase1_out
    && !horizontal_clock_phase1_out && !line_valid_out) else $error("clocking while shutter open");
  pixel_rate_a: assert property (pixel_sample_out |-> gap_reg >= 16'h0064)
    else $error("pixel rate too high");
  rg_per_pixel_a: assert property ($rose(horizontal_clock_phase1_out) |-> $past(reset_gate_out))
    else $error("no reset gate before pixel");
  cover property (frame_done_out);
  cover property ($rose(line_valid_out));
  cover property ($rose(shutter_open_out));
endmodule // ccdt_readout_props
bind ccdt_readout ccdt_readout_props u_ccdt_readout_props (.clk_sys_in, .reset_in, .vertical_clock_phase1_out,
  .vertical_clock_phase2_out, .transfer_gate_out, .horizontal_clock_phase1_out, .horizontal_clock_phase2_out,
  .summing_gate_out, .reset_gate_out, .shutter_open_out, .busy_out, .line_valid_out, .pixel_sample_out,
  .frame_done_out);
`default_nettype wire

// *** verif/ccdt_readout_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccdt_readout_tb_top
  import ccdt_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic clear = 1'b0;
  logic [TIMER_W-1:0] integ = 16'h0000;
  logic [PIXEL_W-1:0] ppl = 11'h000;
  logic v1, v2, tg, h1, h2, sg, rg, shut, busy, lv, ps, done;
  logic [7:0] lines;
  logic [17:0] pixels;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'h013E7038;
  always #5 clk_sys_in = ~clk_sys_in;
  ccdt_readout u_ccdt_readout (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .start_in(start_in),
    .integration_cycles_in(integ), .pixels_per_line_in(ppl), .vertical_clock_phase1_out(v1),
    .vertical_clock_phase2_out(v2), .transfer_gate_out(tg), .horizontal_clock_phase1_out(h1),
    .horizontal_clock_phase2_out(h2), .summing_gate_out(sg), .reset_gate_out(rg), .shutter_open_out(shut),
    .busy_out(busy), .line_valid_out(lv), .pixel_sample_out(ps), .frame_done_out(done));
  ccdt_sensor_model u_ccdt_sensor_model (.vertical_clock_phase1_in(v1), .horizontal_clock_phase1_in(h1),
    .reset_gate_in(rg), .clear_in(clear), .lines_out(lines), .pixels_out(pixels));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic int exp_pixels(input logic [PIXEL_W-1:0] n);
    return (n == 11'h000) ? int'(PIXELS_PER_LINE_DEF) : int'(n);
  endfunction
  function automatic int exp_shutter(input logic [TIMER_W-1:0] n);
    return ((n == 16'h0000) ? 1 : int'(n)) + 1;
  endfunction
  // Start a frame and check the first answer
  task automatic start_frame();
    start_in = 1'b1;
    cyc(1);
    start_in = 1'b0;
    check("start answer", 8'hFC, {shut, busy, v2, tg, h2, sg, v1, h1});
  endtask
  initial begin
    int n;
    cyc(5);
    // Clear the model after time zero so its counts start known
    clear = 1'b1;
    cyc(1);
    reset_in = 1'b0;
    clear = 1'b0;
    // Short lines, random integration, refused restart
    integ = 16'(1 + ($random(seed) & 63));
    ppl = 11'h001;
    start_frame();
    n = 1;
    while (shut === 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
    check("shutter time", exp_shutter(integ), n);
    cyc(100);
    integ = 16'hFFFF;
    ppl = 11'h7FF;
    start_in = 1'b1;
    cyc(1);
    start_in = 1'b0;
    check("restart refused", 0, shut);
    n = 0;
    while (done !== 1'b1 && n < 400000) begin
      cyc(1);
      n++;
    end
    check("frame done", 1, n < 400000);
    check("lines shifted", FRAME_LINES, lines);
    check("pixels shifted", FRAME_LINES * exp_pixels(11'h001), pixels);
    cyc(2);
    check("busy after frame", 0, busy);
    // Default line length, pixel period, reset mid-line
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    ppl = 11'h000;
    integ = 16'($random(seed) & 255);
    start_frame();
    n = 0;
    while (ps !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    cyc(1);
    n = 1;
    while (ps !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    check("pixel period", 400, n);
    check("line valid", 1, lv);
    reset_in = 1'b1;
    cyc(2);
    check("outputs in reset", 0, {v1, v2, tg, h1, h2, sg, rg, shut, busy, lv, ps, done});
    reset_in = 1'b0;
    start_frame();
    print_verdict();
  end
  initial begin
    #6000000;
    num_errors++;
    print_verdict();
  end
endmodule // ccdt_readout_tb_top
`default_nettype wire

// *** verif/ccdt_sensor_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccdt_sensor_model (
  // Sensor clocks
  input wire logic vertical_clock_phase1_in,
  input wire logic horizontal_clock_phase1_in,
  input wire logic reset_gate_in,
  input wire logic clear_in,
  // Shift counts
  output logic [7:0] lines_out,
  output logic [17:0] pixels_out
);
  logic rg_seen;
  always @(posedge clear_in or posedge vertical_clock_phase1_in) begin
    if (clear_in) lines_out <= 8'h00;
    else lines_out <= lines_out + 8'h01;
  end
  always @(posedge clear_in or posedge reset_gate_in or negedge horizontal_clock_phase1_in) begin
    if (clear_in) begin
      pixels_out <= 18'h00000;
      rg_seen <= 1'b0;
    end else if (reset_gate_in) begin
      rg_seen <= 1'b1;
    end else begin
      pixels_out <= pixels_out + {17'h00000, rg_seen};
      rg_seen <= 1'b0;
    end
  end
endmodule // ccdt_sensor_model
`default_nettype wire
